/* logic/acrb_pkg.sv */
// shared constants and types for the converter control register bank
`default_nettype none
package acrb_pkg;
	// word offsets on the register bus (byte address = 4 * index)
	localparam logic [2:0] REG_CONTROL = 3'h0;
	localparam logic [2:0] REG_CONFIG = 3'h1;
	localparam logic [2:0] REG_TRIGNEG = 3'h2;
	localparam logic [2:0] REG_RES_HIGH = 3'h3;
	localparam logic [2:0] REG_RES_LOW = 3'h4;
	localparam logic [2:0] REG_DONE = 3'h5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_GO = 1;
	localparam int BIT_WIDTH10 = 7;
	localparam int BIT_NEGREF = 2;
	localparam int BIT_FORMAT = 7;
	localparam logic [7:0] CONFIG_MASK = 8'hf7;
	// conversion length in conversion clock periods
	localparam int CONV_TCLKS = 15;
	localparam int CLK_HZ = 25000000;
	localparam int RC_DIV = 16;
	typedef struct packed {
		logic [3:0] kind;
		logic [4:0] index;
	} acrb_route_type;
	// analog route kinds
	localparam logic [3:0] ROUTE_NONE = 4'h0;
	localparam logic [3:0] ROUTE_PIN = 4'h1;
	localparam logic [3:0] ROUTE_TEMP = 4'h2;
	localparam logic [3:0] ROUTE_DAC = 4'h3;
	localparam logic [3:0] ROUTE_FVR1 = 4'h4;
	localparam logic [3:0] ROUTE_NREF = 4'h5;
	localparam logic [3:0] ROUTE_GND = 4'h6;
endpackage
`default_nettype wire

/* logic/acrb_top.sv */
// converter control register bank with avalon-mm slave and conversion sequencer
// Functional notes
// [RULE1] control bit 7 set gives 10-bit result layout, clear gives 12-bit
// [RULE2] positive channel codes map to inputs 0-13, 21, temp, dac, fvr1; else none
// [RULE3] writing go starts a conversion; go reads one while converting
// [RULE4] hardware clears go when the conversion finishes
// [RULE5] control bit 0 enables the converter; clear means fully off
// [RULE6] config bit 7 selects two's complement, zero sign-magnitude
// [RULE7] clock field picks osc/2,/8,/32,/4,/16,/64; 011 and 111 pick rc
// [RULE8] config bit 2 picks external negative reference pin, else ground
// [RULE9] positive reference: 00 supply, 01 pin, 11 fixed buffer 1, 10 reserved
// [RULE10] trigger field picks capture_compare_one, capture_compare_two, or pwm unit events; others disabled
// [RULE11] negative channel maps inputs 0-13, 1110 input 21, 1111 negative reference
// [RULE12] converter disabled disconnects every multiplexer input
// [RULE13] sign-magnitude: high holds bits 11..4, low 7..4 holds bits 3..0
// [RULE14] sign-magnitude: low bits 3..1 are zero after a conversion
// [RULE15] sign-magnitude: low bit 0 is the sign
// [RULE16] two's complement: high 7..4 repeat sign, 3..0 hold bits 11..8
// [RULE17] two's complement: low register holds result bits 7..0
// [RULE18] control registers reset to zero; results keep contents across reset
// [RULE19] config bit 3 always reads zero
// [RULE20] setting go clears both result registers first
// [RULE21] completion sets the conversion done flag
// [RULE22] rising edge on the selected trigger sets go
// [RULE23] clearing go early discards the partial result
`timescale 1ns/100ps
`default_nettype none
module acrb_top #(
	parameter int CONV_TCLKS = acrb_pkg::CONV_TCLKS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// trigger event sources
	input wire logic [10:0] trigger_events,
	// analog front end
	input wire logic [11:0] conv_magnitude,
	input wire logic conv_sign,
	output logic converter_enable,
	output logic conv_clk_tick,
	output logic conv_clk_use_rc,
	output acrb_pkg::acrb_route_type pos_route,
	output acrb_pkg::acrb_route_type neg_route,
	output logic [1:0] positive_reference_select,
	output logic negative_reference_select,
	output logic conversion_done_flag
);
	initial begin
		if (CONV_TCLKS < 1 || CONV_TCLKS > 255) begin
			$error("CONV_TCLKS out of range");
		end
	end

	logic rst_meta_reg, rst_sync_reg;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire logic rstn = rst_sync_reg;

	logic [7:0] control_reg, config_reg, trigneg_reg;
	logic [7:0] res_high_reg, res_low_reg;
	logic done_reg;
	logic [7:0] div_reg;
	logic [7:0] tclk_cnt_reg;
	logic ack_reg;
	logic [10:0] trig_prev_reg;

	wire logic [2:0] word = avs_address[4:2];
	// writes land in the answer cycle, the edge at which the master sees waitrequest low
	wire logic wr_take = avs_write && ack_reg && avs_byteenable[0];
	wire logic go = control_reg[acrb_pkg::BIT_GO];

	// one wait state per access keeps read data registered
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read || avs_write) && !ack_reg;
		end
	end

	function automatic logic [3:0] trig_index(input logic [3:0] sel);
		logic [3:0] r;
		r = 4'hf;
		if (sel == 4'h1 || sel == 4'h2) begin
			r = sel - 4'h1;
		end else if (sel >= 4'h4 && sel <= 4'hc) begin
			r = sel - 4'h2;
		end
		return r;
	endfunction

	wire logic [3:0] tsel = trigneg_reg[7:4];
	wire logic [3:0] tidx = trig_index(tsel); // [RULE10]
	// one edge detector per source; a disabled code gives tidx 4'hf, past the vector, and the tidx != 4'hf test masks it
	logic [10:0] trig_edge;
	for (genvar g = 0; g < 11; g++) begin : g_edge
		assign trig_edge[g] = trigger_events[g] && !trig_prev_reg[g];
	end
	wire logic trig_rise = (tidx != 4'hf) && trig_edge[tidx]; // [RULE22]

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trig_prev_reg <= 11'h000;
		end else begin
			trig_prev_reg <= trigger_events;
		end
	end

	// conversion clock divider; rc codes tick from an assumed internal rc at RC_DIV
	logic [7:0] div_len;
	always_comb begin
		unique case (config_reg[6:4]) // [RULE7]
			3'h0: div_len = 8'h02;
			3'h1: div_len = 8'h08;
			3'h2: div_len = 8'h20;
			3'h4: div_len = 8'h04;
			3'h5: div_len = 8'h10;
			3'h6: div_len = 8'h40;
			default: div_len = 8'(acrb_pkg::RC_DIV);
		endcase
	end
	assign conv_clk_use_rc = (config_reg[5:4] == 2'h3); // [RULE7]
	wire logic tick = go && (div_reg == div_len - 8'h01);
	assign conv_clk_tick = tick;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_reg <= 8'h00;
		end else if (!go || tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	wire logic finish = go && tick && (tclk_cnt_reg == 8'(CONV_TCLKS - 1));
	wire logic sw_go_set = wr_take && word == acrb_pkg::REG_CONTROL &&
		avs_writedata[acrb_pkg::BIT_GO] && !go;
	wire logic start = (sw_go_set || (trig_rise && !go)) &&
		control_reg[acrb_pkg::BIT_ENABLE];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tclk_cnt_reg <= 8'h00;
		end else if (!go) begin
			tclk_cnt_reg <= 8'h00;
		end else if (tick) begin
			tclk_cnt_reg <= tclk_cnt_reg + 8'h01;
		end
	end

	// control register; go written one only when enabled
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			control_reg <= acrb_pkg::CTRL_RESET; // [RULE18]
		end else begin
			if (wr_take && word == acrb_pkg::REG_CONTROL) begin
				control_reg <= {avs_writedata[7:2], start, avs_writedata[0]}; // [RULE3]
				if (go && avs_writedata[acrb_pkg::BIT_GO]) begin
					control_reg[acrb_pkg::BIT_GO] <= !finish;
				end
			end else if (start) begin
				control_reg[acrb_pkg::BIT_GO] <= 1'b1; // [RULE22]
			end else if (finish || !control_reg[acrb_pkg::BIT_ENABLE]) begin
				control_reg[acrb_pkg::BIT_GO] <= 1'b0; // [RULE4]
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			config_reg <= acrb_pkg::CTRL_RESET;
			trigneg_reg <= acrb_pkg::CTRL_RESET;
		end else if (wr_take && word == acrb_pkg::REG_CONFIG) begin
			config_reg <= avs_writedata[7:0] & acrb_pkg::CONFIG_MASK; // [RULE19]
		end else if (wr_take && word == acrb_pkg::REG_TRIGNEG) begin
			trigneg_reg <= avs_writedata[7:0];
		end
	end

	// done flag: hardware set wins over software write-one-to-clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			done_reg <= 1'b0;
		end else if (finish) begin
			done_reg <= 1'b1; // [RULE21]
		end else if (wr_take && word == acrb_pkg::REG_DONE && avs_writedata[0]) begin
			done_reg <= 1'b0;
		end
	end
	assign conversion_done_flag = done_reg;

	// result formatting; 10-bit mode drops the two lowest magnitude bits
	logic [11:0] mag;
	logic [12:0] twos;
	logic [7:0] fmt_high, fmt_low;
	always_comb begin
		mag = control_reg[acrb_pkg::BIT_WIDTH10] ? {conv_magnitude[11:2], 2'h0} : conv_magnitude; // [RULE1]
		twos = conv_sign ? 13'(-{1'b0, mag}) : {1'b0, mag};
		if (config_reg[acrb_pkg::BIT_FORMAT]) begin // [RULE6]
			fmt_high = {{4{twos[12]}}, twos[11:8]}; // [RULE16]
			fmt_low = twos[7:0]; // [RULE17]
		end else begin
			fmt_high = mag[11:4]; // [RULE13]
			fmt_low = {mag[3:0], 3'h0, conv_sign}; // [RULE14] [RULE15]
		end
	end

	// results have no reset so their contents survive a reset
	always_ff @(posedge core_clk) begin // [RULE18]
		if (start) begin
			res_high_reg <= 8'h00; // [RULE20]
			res_low_reg <= 8'h00;
		end else if (finish) begin
			res_high_reg <= fmt_high; // [RULE23]
			res_low_reg <= fmt_low;
		end else if (wr_take && word == acrb_pkg::REG_RES_HIGH) begin
			res_high_reg <= avs_writedata[7:0];
		end else if (wr_take && word == acrb_pkg::REG_RES_LOW) begin
			res_low_reg <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_reg) begin
			unique case (word)
				acrb_pkg::REG_CONTROL: avs_readdata <= {24'h0, control_reg};
				acrb_pkg::REG_CONFIG: avs_readdata <= {24'h0, config_reg};
				acrb_pkg::REG_TRIGNEG: avs_readdata <= {24'h0, trigneg_reg};
				acrb_pkg::REG_RES_HIGH: avs_readdata <= {24'h0, res_high_reg};
				acrb_pkg::REG_RES_LOW: avs_readdata <= {24'h0, res_low_reg};
				acrb_pkg::REG_DONE: avs_readdata <= {31'h0, done_reg};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// analog routing
	wire logic en = control_reg[acrb_pkg::BIT_ENABLE];
	assign converter_enable = en; // [RULE5]
	assign positive_reference_select = config_reg[1:0]; // [RULE9]
	assign negative_reference_select = config_reg[acrb_pkg::BIT_NEGREF]; // [RULE8]
	always_comb begin
		pos_route = '{kind: acrb_pkg::ROUTE_NONE, index: 5'h00};
		neg_route = '{kind: acrb_pkg::ROUTE_NONE, index: 5'h00};
		if (en) begin // [RULE12]
			unique case (control_reg[6:2]) inside // [RULE2]
				[5'h00:5'h0d]: pos_route = '{kind: acrb_pkg::ROUTE_PIN, index: control_reg[6:2]};
				5'h15: pos_route = '{kind: acrb_pkg::ROUTE_PIN, index: 5'h15};
				5'h1d: pos_route.kind = acrb_pkg::ROUTE_TEMP;
				5'h1e: pos_route.kind = acrb_pkg::ROUTE_DAC;
				5'h1f: pos_route.kind = acrb_pkg::ROUTE_FVR1;
				default: pos_route.kind = acrb_pkg::ROUTE_NONE;
			endcase
			unique case (trigneg_reg[3:0]) inside // [RULE11]
				4'he: neg_route = '{kind: acrb_pkg::ROUTE_PIN, index: 5'h15};
				4'hf: neg_route.kind = config_reg[acrb_pkg::BIT_NEGREF] ?
					acrb_pkg::ROUTE_NREF : acrb_pkg::ROUTE_GND;
				default: neg_route = '{kind: acrb_pkg::ROUTE_PIN, index: {1'b0, trigneg_reg[3:0]}};
			endcase
		end
	end

	go_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
		finish |=> !go && done_reg) else $error("go not cleared at finish"); // [RULE4]
	start_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
		start |=> go && res_high_reg == 8'h00 && res_low_reg == 8'h00)
		else $error("start did not clear results"); // [RULE20]
	off_disconnects_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!en |-> pos_route.kind == acrb_pkg::ROUTE_NONE && neg_route.kind == acrb_pkg::ROUTE_NONE)
		else $error("mux connected while off"); // [RULE12]
	cfg_bit3_a: assert property (@(posedge core_clk) disable iff (!rstn)
		config_reg[3] == 1'b0) else $error("config bit 3 set"); // [RULE19]
	abort_keeps_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$fell(go) && !$past(finish) && !$past(wr_take && word == acrb_pkg::REG_RES_HIGH) |-> $stable(res_high_reg))
		else $error("abort changed result"); // [RULE23]
	sm_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
		finish && !config_reg[7] |=> res_low_reg[3:1] == 3'h0 && res_low_reg[0] == $past(conv_sign))
		else $error("sign-magnitude low wrong"); // [RULE15]
	tc_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
		finish && config_reg[7] |=> res_high_reg[7:4] == {4{$past(conv_sign && mag != 12'h000)}})
		else $error("twos complement sign wrong"); // [RULE16]
	trig_go_a: assert property (@(posedge core_clk) disable iff (!rstn)
		trig_rise && en && !go && !wr_take |=> go) else $error("trigger did not start"); // [RULE22]

	// a software go with the converter on must read back as busy
	go_reads_a: assert property (@(posedge core_clk) disable iff (!rstn)
		sw_go_set && en |=> go) else $error("go not set by write"); // [RULE3]
	// only an enabled converter may start
	start_needs_en_a: assert property (@(posedge core_clk) disable iff (!rstn)
		start |-> en) else $error("start while disabled"); // [RULE3]
	// turning the converter off also ends any conversion
	off_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!en |=> !go) else $error("busy while disabled"); // [RULE5]
	// the conversion clock only runs while busy
	idle_tick_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!go |-> !conv_clk_tick) else $error("tick while idle"); // [RULE3]
	// every divider is at least two, so ticks never touch
	tick_gap_a: assert property (@(posedge core_clk) disable iff (!rstn)
		tick |=> !tick) else $error("ticks back to back"); // [RULE7]
	// both rc codes, and only those, select the rc clock
	rc_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
		conv_clk_use_rc == (config_reg[6:4] == 3'h3 || config_reg[6:4] == 3'h7))
		else $error("rc select wrong"); // [RULE7]
	// the done flag stays until software clears it
	done_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		done_reg && !(wr_take && word == acrb_pkg::REG_DONE) |=> done_reg)
		else $error("done flag lost"); // [RULE21]
	// sign-magnitude places the magnitude left justified
	sm_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
		finish && !config_reg[acrb_pkg::BIT_FORMAT] |=> res_high_reg == $past(mag[11:4])
		&& res_low_reg[7:4] == $past(mag[3:0])) else $error("sign-magnitude high wrong"); // [RULE13]
	// a positive two's complement result keeps its low byte
	tc_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
		finish && config_reg[acrb_pkg::BIT_FORMAT] && !conv_sign |=> res_low_reg == $past(mag[7:0]))
		else $error("twos complement low wrong"); // [RULE17]
	// 10-bit layout leaves the two lowest magnitude bits clear
	width10_a: assert property (@(posedge core_clk) disable iff (!rstn)
		finish && control_reg[acrb_pkg::BIT_WIDTH10] && !config_reg[acrb_pkg::BIT_FORMAT]
		|=> res_low_reg[5:4] == 2'h0) else $error("10-bit layout wrong"); // [RULE1]
	// negative channel 1111 follows the negative reference bit
	nref_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
		en && trigneg_reg[3:0] == 4'hf |-> neg_route.kind == (config_reg[acrb_pkg::BIT_NEGREF] ?
		acrb_pkg::ROUTE_NREF : acrb_pkg::ROUTE_GND)) else $error("negative reference route wrong"); // [RULE11]
	neg_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
		en && trigneg_reg[3:0] == 4'he |-> neg_route.index == 5'h15)
		else $error("negative input 21 wrong"); // [RULE11]
	// reserved positive channel codes connect nothing
	pos_none_a: assert property (@(posedge core_clk) disable iff (!rstn)
		en && control_reg[6:2] inside {[5'h0e:5'h14], [5'h16:5'h1c]} |-> pos_route.kind == acrb_pkg::ROUTE_NONE)
		else $error("reserved channel connected"); // [RULE2]
	// disabled trigger codes never start a conversion
	trig_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
		tsel == 4'h0 || tsel == 4'h3 || tsel >= 4'hd |-> !trig_rise)
		else $error("disabled trigger fired"); // [RULE10]
	// every request is stalled exactly in its first cycle
	wait_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(avs_read || avs_write) && !ack_reg |-> avs_waitrequest)
		else $error("first cycle not stalled");
	// read data in the answer cycle is the register as it stood a cycle earlier
	readback_a: assert property (@(posedge core_clk) disable iff (!rstn)
		avs_read && ack_reg && word == acrb_pkg::REG_CONTROL |-> avs_readdata[7:0] == $past(control_reg))
		else $error("control readback wrong"); // [RULE3]
	cfg_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
		avs_read && ack_reg && word == acrb_pkg::REG_CONFIG |-> !avs_readdata[3])
		else $error("config bit 3 read as one"); // [RULE19]
endmodule
`default_nettype wire

/* testbench/test_acrb_top.sv */
// self-checking bench for the converter control register bank
`timescale 1ns/100ps
`default_nettype none
module test_acrb_top;
	logic core_clk, resetn, avs_read, avs_write, avs_waitrequest, converter_enable, conv_clk_tick, conv_sign;
	logic conv_clk_use_rc, negative_reference_select, conversion_done_flag;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [10:0] trigger_events;
	logic [11:0] conv_magnitude;
	logic [1:0] positive_reference_select;
	logic [7:0] v, c;
	logic [15:0] e;
	acrb_pkg::acrb_route_type pos_route, neg_route;
	int error_cnt, compares, seed, n, k, t;
	int divs[8] = '{2, 8, 32, acrb_pkg::RC_DIV, 4, 16, 64, acrb_pkg::RC_DIV};
	// short conversions keep the run brief
	acrb_top #(.CONV_TCLKS(2)) DUT (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.trigger_events(trigger_events), .conv_magnitude(conv_magnitude), .conv_sign(conv_sign),
		.converter_enable(converter_enable), .conv_clk_tick(conv_clk_tick), .conv_clk_use_rc(conv_clk_use_rc),
		.pos_route(pos_route), .neg_route(neg_route), .positive_reference_select(positive_reference_select),
		.negative_reference_select(negative_reference_select), .conversion_done_flag(conversion_done_flag));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// request is held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d);
		int b;
		@(posedge core_clk);
		avs_address <= {i, 2'b00};
		avs_writedata <= {$random(seed) & 32'hffffff00} | d;
		avs_write <= w;
		avs_read <= !w;
		b = 0;
		@(negedge core_clk);
		while (avs_waitrequest !== 1'b0 && b < 100) begin
			@(negedge core_clk);
			b++;
		end
		if (b >= 100) error_cnt++;
		@(posedge core_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask
	task automatic rd(input string w, input logic [2:0] i, input logic [7:0] x);
		bus(1'b0, i, 8'h00);
		check(w, q, {24'h0, x});
	endtask
	task automatic wait_idle;
		int b;
		b = 0;
		bus(1'b0, acrb_pkg::REG_CONTROL, 8'h00);
		while (q[1] !== 1'b0 && b < 200) begin
			bus(1'b0, acrb_pkg::REG_CONTROL, 8'h00);
			b++;
		end
	endtask
	function automatic logic [15:0] expres(input logic fm, input logic w10, input logic s, input logic [11:0] m);
		logic [11:0] mm;
		logic [12:0] x;
		mm = w10 ? {m[11:2], 2'b00} : m;
		x = s ? -{1'b0, mm} : {1'b0, mm};
		return fm ? {{4{x[12]}}, x[11:0]} : {mm, 3'b000, s};
	endfunction
	function automatic logic [3:0] pkind(input logic en, input logic [4:0] x);
		if (!en) return acrb_pkg::ROUTE_NONE;
		if (x <= 5'd13 || x == 5'd21) return acrb_pkg::ROUTE_PIN;
		if (x == 5'd29) return acrb_pkg::ROUTE_TEMP;
		if (x == 5'd30) return acrb_pkg::ROUTE_DAC;
		if (x == 5'd31) return acrb_pkg::ROUTE_FVR1;
		return acrb_pkg::ROUTE_NONE;
	endfunction
	function automatic logic [3:0] nkind(input logic en, input logic [3:0] x, input logic r);
		if (!en) return acrb_pkg::ROUTE_NONE;
		if (x == 4'hf) return r ? acrb_pkg::ROUTE_NREF : acrb_pkg::ROUTE_GND;
		return acrb_pkg::ROUTE_PIN;
	endfunction
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		error_cnt++;
		complete_run();
	end
	initial begin
		seed = 32'h71a52dd2;
		{resetn, avs_read, avs_write, conv_sign} = 4'h0;
		{avs_address, avs_writedata, avs_byteenable, trigger_events, conv_magnitude} = '0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		avs_byteenable <= 4'h1;
		repeat (3) @(posedge core_clk);
		rd("control", acrb_pkg::REG_CONTROL, 8'h00);
		rd("unmapped", 3'h6, 8'h00);
		for (n = 0; n < 64; n++) begin
			v = $random(seed);
			if (v[1:0] == 2'b10) v[1:0] = 2'b11;
			wr(acrb_pkg::REG_CONFIG, v);
			wr(acrb_pkg::REG_TRIGNEG, {4'h0, n[3:0]});
			wr(acrb_pkg::REG_CONTROL, {1'b0, n[4:0], 1'b0, n[5]});
			rd("config", acrb_pkg::REG_CONFIG, v & 8'hf7);
			check("enable", converter_enable, n[5]);
			check("rc", conv_clk_use_rc, v[5:4] == 2'b11);
			check("pref", positive_reference_select, v[1:0]);
			check("nref", negative_reference_select, v[2]);
			check("pos kind", pos_route.kind, pkind(n[5], n[4:0]));
			check("neg kind", neg_route.kind, nkind(n[5], n[3:0], v[2]));
			if (pos_route.kind === acrb_pkg::ROUTE_PIN) check("pos idx", pos_route.index, n[4:0]);
			if (neg_route.kind === acrb_pkg::ROUTE_PIN) check("neg idx", neg_route.index, n[3:0] == 4'he ? 21 : n[3:0]);
		end
		for (n = 0; n < 8; n++) begin
			wr(acrb_pkg::REG_CONFIG, {1'b0, n[2:0], 4'h0});
			wr(acrb_pkg::REG_CONTROL, 8'h01);
			wr(acrb_pkg::REG_CONTROL, 8'h03);
			for (k = 0; conv_clk_tick !== 1'b1 && k < 200; k++) @(negedge core_clk);
			@(negedge core_clk);
			for (k = 1; conv_clk_tick !== 1'b1 && k < 200; k++) @(negedge core_clk);
			check("tick period", k, divs[n]);
			wait_idle();
		end
		for (n = 0; n < 12; n++) begin
			c = {$random(seed)} & 8'hfc;
			v = ({$random(seed)} & 8'h8f) | 8'h60;
			conv_magnitude <= $random(seed);
			conv_sign <= $random(seed);
			wr(acrb_pkg::REG_CONFIG, v);
			wr(acrb_pkg::REG_DONE, 8'h01);
			wr(acrb_pkg::REG_CONTROL, c | 8'h01);
			wr(acrb_pkg::REG_CONTROL, c | 8'h03);
			rd("go busy", acrb_pkg::REG_CONTROL, c | 8'h03);
			rd("cleared", acrb_pkg::REG_RES_HIGH, 8'h00);
			wait_idle();
			check("go done", q[7:0], c | 8'h01);
			check("done flag", conversion_done_flag, 1'b1);
			e = expres(v[7], c[7], conv_sign, conv_magnitude);
			rd("res high", acrb_pkg::REG_RES_HIGH, e[15:8]);
			rd("res low", acrb_pkg::REG_RES_LOW, e[7:0]);
		end
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd("config rst", acrb_pkg::REG_CONFIG, 8'h00);
		rd("trig rst", acrb_pkg::REG_TRIGNEG, 8'h00);
		rd("res kept", acrb_pkg::REG_RES_HIGH, e[15:8]);
		wr(acrb_pkg::REG_CONFIG, 8'h60);
		wr(acrb_pkg::REG_CONTROL, 8'h01);
		wr(acrb_pkg::REG_CONTROL, 8'h03);
		wr(acrb_pkg::REG_CONTROL, 8'h01);
		repeat (200) @(posedge core_clk);
		check("abort flag", conversion_done_flag, 1'b0);
		rd("abort res", acrb_pkg::REG_RES_HIGH, 8'h00);
		wr(acrb_pkg::REG_CONFIG, 8'h00);
		for (n = 0; n < 16; n++) begin
			t = (n == 1 || n == 2) ? n - 1 : (n >= 4 && n <= 12) ? n - 2 : -1;
			wr(acrb_pkg::REG_TRIGNEG, {n[3:0], 4'h0});
			wr(acrb_pkg::REG_DONE, 8'h01);
			trigger_events <= (t < 0) ? 11'h7ff : 11'h001 << t;
			repeat (20) @(posedge core_clk);
			check("trigger", conversion_done_flag, t >= 0);
			trigger_events <= 11'h000;
		end
		complete_run();
	end
endmodule
`default_nettype wire
